// ===== core/ebu_map.svh
// Bit positions, field layouts and reset values of the external bus unit.
`ifndef EBU_MAP_SVH
`define EBU_MAP_SVH

// Bus configuration word fields.
`define EBU_CFG_WIDTH8   0
`define EBU_CFG_MUXED    1
`define EBU_CFG_WAIT_LO  2
`define EBU_CFG_WAIT_HI  5
`define EBU_CFG_TRI      6
`define EBU_CFG_ALE_LONG 7
`define EBU_CFG_RWDLY    8
`define EBU_CFG_RDY_EN   9
`define EBU_CFG_RDY_POL  10
`define EBU_CFG_CS_EN    11

// Window range select fields: size code in the low nibble, base address bits 23..12 above.
`define EBU_RNG_SIZE_HI  3
`define EBU_RNG_BASE_LO  4
`define EBU_RNG_BASE_HI  15

// Address space codes and the segment line masks that go with them.
`define EBU_SPACE_16M    2'h0
`define EBU_SPACE_1M     2'h1
`define EBU_SPACE_256K   2'h2
`define EBU_SPACE_64K    2'h3
`define EBU_SEG_MASK_16M  8'hff
`define EBU_SEG_MASK_1M   8'h0f
`define EBU_SEG_MASK_256K 8'h03
`define EBU_SEG_MASK_64K  8'h00

// Reset values.
// Least access length while READY is enabled: the filtered READY and data inputs lag four clocks,
// so a shorter access would end on the READY level left over from the previous cycle.
`define EBU_RDY_SETTLE   4'h4

`define EBU_RST_CNT      4'h0
`define EBU_RST_WIN      3'h0
`define EBU_RST_CFG      16'h0000
`define EBU_RST_ADDR     24'h000000
`define EBU_RST_DATA     16'h0000
`define EBU_RST_CS_N     5'h1f
`define EBU_RST_SYNC     19'h00000

`endif

// ===== core/ebu_pkg.sv
// Types shared by the external bus unit.
package ebu_pkg;

	typedef enum logic [2:0] {
		EBU_IDLE     = 3'h0,
		EBU_ADDR     = 3'h1,
		EBU_DELAY    = 3'h3,
		EBU_ACCESS   = 3'h2,
		EBU_RECOVER  = 3'h6,
		EBU_HOLDWAIT = 3'h4,
		EBU_HELD     = 3'h5
	} ebu_state_e;

	typedef logic [15:0] ebu_word_t;

endpackage

// ===== core/ebu_external_bus_unit.sv
// External bus unit: runs CPU memory requests as cycles on the external parallel bus.
`timescale 1ns/1ps
`default_nettype none
`include "ebu_map.svh"

// Behaviour
// RL1: single_chip_mode refuses every request with an error and makes no bus cycle.
// RL2: multiplexed or demultiplexed, 8- or 16-bit data, 16/18/20/24-bit addresses.
// RL3: demultiplexed cycles put address on address_port, data on data port or low byte.
// RL4: multiplexed cycles put address on data port during latch phase, then data.
// RL5: cycle wait, tri-state recovery, latch strobe length and strobe delay are programmable.
// RL6: four windows, each a range select plus its own bus configuration.
// RL7: window four beats three, window two beats one; higher index wins overall.
// RL8: addresses outside all windows use default_bus_config.
// RL9: five active-low chip selects, one per window plus the default range.
// RL10: READY input lets slow devices stretch a cycle.
// RL11: arbitration_enable hands request, grant and hold pins to this unit.
// RL12: after reset the unit is arbitration master, grant pin driven.
// RL13: arb_pin_direction_bit set selects slave mode, grant pin becomes input.
// RL14: address space selects eight, four, two or zero segment address lines.
// RL15: by default chip selects change one clock after the latch strobe rises.
// RL16: with select_timing_config set chip selects change with the latch strobe edge.
// RL17: READY active level comes from each configuration's ready polarity bit.
// RL18: the device in a ready window must end each cycle with READY active.
// RL19: while READY is inactive the cycle waits with address, strobes and selects held.
// RL20: master yields after the current cycle, floats the bus, then grants until released.
module ebu_external_bus_unit
	import ebu_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        req_valid,
	output var  logic        req_ready,
	input  wire logic        req_write,
	input  wire logic [23:0] req_addr,
	input  wire ebu_word_t   req_wdata,
	output var  logic        rsp_valid,
	output var  ebu_word_t   rsp_rdata,
	output var  logic        rsp_error,
	input  wire logic        single_chip_mode,
	input  wire logic [1:0]  address_space_sel,
	input  wire ebu_word_t   window_range_select [4],
	input  wire ebu_word_t   window_bus_config [4],
	input  wire ebu_word_t   default_bus_config,
	input  wire logic        select_timing_config,
	input  wire logic        arbitration_enable,
	input  wire logic        arb_pin_direction_bit,
	output var  logic [15:0] address_port,
	output var  logic [7:0]  segment_address,
	output var  logic        bus_oe,
	output var  ebu_word_t   muxed_data_port_o,
	output var  logic [15:0] muxed_data_port_oe,
	input  wire ebu_word_t   muxed_data_port_i,
	output var  logic        ale,
	output var  logic        rd_n,
	output var  logic        wr_n,
	output var  logic [4:0]  chip_select_n,
	input  wire logic        ready_in,
	input  wire logic        hold_request_in,
	output var  logic        bus_request_out,
	output var  logic        bus_yield_grant_o,
	output var  logic        bus_yield_grant_oe,
	input  wire logic        bus_yield_grant_i
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: three stages, a change counts when stages two and three agree.

	logic [18:0] sync1;
	logic [18:0] sync2;
	logic [18:0] sync3;
	logic [18:0] filt;
	wire  [18:0] pins_in = {hold_request_in, bus_yield_grant_i, ready_in, muxed_data_port_i};
	wire  [18:0] next_filt = (sync2 & sync3) | (filt & (sync2 | sync3));

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sync1 <= `EBU_RST_SYNC;
			sync2 <= `EBU_RST_SYNC;
			sync3 <= `EBU_RST_SYNC;
			filt  <= `EBU_RST_SYNC;
		end else begin
			sync1 <= pins_in;
			sync2 <= sync1;
			sync3 <= sync2;
			filt  <= next_filt;
		end
	end

	wire       hold_s  = filt[18];
	wire       grant_s = filt[17];
	wire       ready_s = filt[16];
	ebu_word_t data_s;
	assign data_s = filt[15:0];

	////////////////////////////////////////////////////////////////////////
	// Window decode.

	logic [3:0] hit;

	generate
		for (genvar w = 0; w < 4; w++) begin : g_win
			wire [3:0]  size_code = window_range_select[w][`EBU_RNG_SIZE_HI:0];
			wire [11:0] base      = window_range_select[w][`EBU_RNG_BASE_HI:`EBU_RNG_BASE_LO];
			assign hit[w] = ((req_addr[23:12] ^ base) >> size_code) == 12'h000; // RL6
		end
	endgenerate

	// Higher windows take precedence over lower ones, default when none hits.
	wire [2:0] win_sel = hit[3] ? 3'h4 : hit[2] ? 3'h3 : hit[1] ? 3'h2 : hit[0] ? 3'h1 : 3'h0; // RL7 RL8
	ebu_word_t cfg_sel;
	assign cfg_sel = (win_sel == 3'h0) ? default_bus_config : window_bus_config[win_sel[1:0] - 2'h1]; // RL6 RL8

	////////////////////////////////////////////////////////////////////////
	// Cycle state.

	ebu_state_e state;
	ebu_state_e next_state;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic [23:0] addr;
	logic [23:0] next_addr;
	ebu_word_t  wdata;
	ebu_word_t  next_wdata;
	logic       write;
	logic       next_write;
	logic [2:0] win;
	logic [2:0] next_win;
	ebu_word_t  cfg;
	ebu_word_t  next_cfg;
	logic       next_rsp_valid;
	ebu_word_t  next_rsp_rdata;
	logic       next_rsp_error;

	wire slave    = arb_pin_direction_bit; // RL13
	wire accept   = req_valid & req_ready;
	wire width8   = cfg[`EBU_CFG_WIDTH8];
	wire muxed    = cfg[`EBU_CFG_MUXED];
	wire [3:0] wait_cnt = cfg[`EBU_CFG_WAIT_HI:`EBU_CFG_WAIT_LO];
	wire rdy_ok   = !cfg[`EBU_CFG_RDY_EN] || (ready_s == cfg[`EBU_CFG_RDY_POL]); // RL10 RL17 RL18
	wire hold_go  = arbitration_enable && !slave && hold_s; // RL11 RL20

	// A READY window waits out the input filter before READY is trusted.
	wire rdy_short = cfg[`EBU_CFG_RDY_EN] && (wait_cnt < `EBU_RDY_SETTLE);
	wire [3:0] acc_cnt = rdy_short ? `EBU_RDY_SETTLE : wait_cnt; // RL10 RL19
	wire [3:0] ale_len  = {3'h0, cfg_sel[`EBU_CFG_ALE_LONG]};
	ebu_word_t rd_word;
	assign rd_word = width8 ? {8'h00, data_s[7:0]} : data_s; // RL3

	always_comb begin
		next_state     = state;
		next_cnt       = cnt;
		next_addr      = addr;
		next_wdata     = wdata;
		next_write     = write;
		next_win       = win;
		next_cfg       = cfg;
		next_rsp_valid = 1'b0;
		next_rsp_rdata = rsp_rdata;
		next_rsp_error = 1'b0;
		unique case (state)
			EBU_IDLE: begin
				if (accept && single_chip_mode) begin
					next_rsp_valid = 1'b1; // RL1
					next_rsp_error = 1'b1;
				end else if (accept) begin
					next_state = EBU_ADDR;
					next_cnt   = ale_len; // RL5
					next_addr  = req_addr;
					next_wdata = req_wdata;
					next_write = req_write;
					next_win   = win_sel;
					next_cfg   = cfg_sel;
				end else if (hold_go) begin
					next_state = EBU_HOLDWAIT; // RL20
				end
			end
			EBU_ADDR: begin
				if (cnt != 4'h0) begin
					next_cnt = cnt - 4'h1;
				end else begin
					next_state = cfg[`EBU_CFG_RWDLY] ? EBU_DELAY : EBU_ACCESS; // RL5
					next_cnt   = acc_cnt;
				end
			end
			EBU_DELAY: begin
				next_state = EBU_ACCESS;
			end
			EBU_ACCESS: begin
				if (cnt != 4'h0) begin
					next_cnt = cnt - 4'h1; // RL5
				end else if (rdy_ok) begin
					next_state     = cfg[`EBU_CFG_TRI] ? EBU_RECOVER : EBU_IDLE; // RL5
					next_rsp_valid = 1'b1;
					next_rsp_rdata = write ? rsp_rdata : rd_word;
				end
			end
			EBU_RECOVER: begin
				next_state = EBU_IDLE;
			end
			EBU_HOLDWAIT: begin
				next_state = EBU_HELD; // RL20
			end
			EBU_HELD: begin
				if (!hold_s) begin
					next_state = EBU_IDLE; // RL20
				end
			end
			default: begin
				next_state = EBU_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= EBU_IDLE;
			cnt   <= `EBU_RST_CNT;
			addr  <= `EBU_RST_ADDR;
			wdata <= `EBU_RST_DATA;
			write <= 1'b0;
			win   <= `EBU_RST_WIN;
			cfg   <= `EBU_RST_CFG;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			addr  <= next_addr;
			wdata <= next_wdata;
			write <= next_write;
			win   <= next_win;
			cfg   <= next_cfg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin values for the coming cycle, registered below.

	wire n_cycle  = (next_state == EBU_ADDR) || (next_state == EBU_DELAY) || (next_state == EBU_ACCESS);
	wire n_held   = (next_state == EBU_HOLDWAIT) || (next_state == EBU_HELD);
	wire n_granted = !arbitration_enable || !slave || grant_s || (next_state != EBU_IDLE);
	wire n_bus_oe = !n_held && n_granted; // RL20 RL13
	wire n_ready  = (next_state == EBU_IDLE) && !hold_go && n_granted;
	wire n_muxed  = next_cfg[`EBU_CFG_MUXED];
	wire n_w8     = next_cfg[`EBU_CFG_WIDTH8];
	wire n_strobe = next_state == EBU_ACCESS;
	// Selects follow the strobe edge when fast, otherwise one clock later.
	wire n_cs_on  = n_cycle && (select_timing_config || (state != EBU_IDLE)) && next_cfg[`EBU_CFG_CS_EN]; // RL15 RL16
	logic [4:0] next_cs_n;
	logic [7:0] seg_mask;
	ebu_word_t  next_dout;
	logic [15:0] next_doe;

	always_comb begin
		next_cs_n = `EBU_RST_CS_N;
		if (n_cs_on) begin
			next_cs_n[next_win] = 1'b0; // RL9 RL19
		end
	end

	always_comb begin
		unique case (address_space_sel)
			`EBU_SPACE_16M:  seg_mask = `EBU_SEG_MASK_16M; // RL14
			`EBU_SPACE_1M:   seg_mask = `EBU_SEG_MASK_1M;
			`EBU_SPACE_256K: seg_mask = `EBU_SEG_MASK_256K;
			`EBU_SPACE_64K:  seg_mask = `EBU_SEG_MASK_64K;
		endcase
	end

	always_comb begin
		next_dout = next_wdata;
		next_doe  = 16'h0000;
		if (n_bus_oe && n_muxed && (next_state == EBU_ADDR)) begin
			next_dout = next_addr[15:0]; // RL4
			next_doe  = 16'hffff;
		end else if (n_bus_oe && next_write && ((next_state == EBU_DELAY) || n_strobe)) begin
			next_doe  = n_w8 ? 16'h00ff : 16'hffff; // RL3 RL2
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			req_ready          <= 1'b0;
			rsp_valid          <= 1'b0;
			rsp_rdata          <= `EBU_RST_DATA;
			rsp_error          <= 1'b0;
			address_port       <= `EBU_RST_DATA;
			segment_address    <= 8'h00;
			bus_oe             <= 1'b1;
			muxed_data_port_o  <= `EBU_RST_DATA;
			muxed_data_port_oe <= 16'h0000;
			ale                <= 1'b0;
			rd_n               <= 1'b1;
			wr_n               <= 1'b1;
			chip_select_n      <= `EBU_RST_CS_N;
			bus_request_out    <= 1'b0;
			bus_yield_grant_o  <= 1'b0;
			bus_yield_grant_oe <= 1'b0;
		end else begin
			req_ready          <= n_ready;
			rsp_valid          <= next_rsp_valid;
			rsp_rdata          <= next_rsp_rdata;
			rsp_error          <= next_rsp_error;
			address_port       <= next_addr[15:0]; // RL3
			segment_address    <= next_addr[23:16] & seg_mask; // RL14
			bus_oe             <= n_bus_oe;
			muxed_data_port_o  <= next_dout;
			muxed_data_port_oe <= next_doe;
			ale                <= next_state == EBU_ADDR; // RL5
			rd_n               <= !(n_strobe && !next_write); // RL19
			wr_n               <= !(n_strobe && next_write);
			chip_select_n      <= next_cs_n;
			bus_request_out    <= arbitration_enable && slave && (req_valid || n_cycle); // RL11 RL13
			bus_yield_grant_o  <= next_state == EBU_HELD; // RL20
			bus_yield_grant_oe <= arbitration_enable && !slave; // RL12 RL13
		end
	end

endmodule
`default_nettype wire

// ===== bench/ebu_sva.sv
// Port checker of the external bus unit.
`timescale 1ns/1ps
`default_nettype none
module ebu_sva (
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic        rsp_valid,
	input wire logic        rsp_error,
	input wire logic        single_chip_mode,
	input wire logic [1:0]  address_space_sel,
	input wire logic        select_timing_config,
	input wire logic        arb_pin_direction_bit,
	input wire logic [15:0] address_port,
	input wire logic [7:0]  segment_address,
	input wire logic        bus_oe,
	input wire logic        ale,
	input wire logic        rd_n,
	input wire logic [4:0]  chip_select_n,
	input wire logic        bus_yield_grant_o,
	input wire logic        bus_yield_grant_oe
);
	logic [7:0] seg_mask;
	assign seg_mask = (address_space_sel == 2'h0) ? 8'hff : (address_space_sel == 2'h1) ? 8'h0f :
		(address_space_sel == 2'h2) ? 8'h03 : 8'h00;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	a_single_chip: assert property (single_chip_mode && req_valid && req_ready |=> rsp_valid && rsp_error && !ale)
		else $error("single-chip request not refused");
	a_one_select: assert property ($countones(~chip_select_n) <= 1)
		else $error("more than one chip select low");
	a_segment_lines: assert property (ale |-> (segment_address & ~seg_mask) == 8'h00)
		else $error("segment line outside address space");
	a_wait_hold: assert property (!rd_n && !$past(rd_n) |-> $stable(address_port) && $stable(chip_select_n))
		else $error("address or select moved during wait");
	a_float_first: assert property ($rose(bus_yield_grant_o) |-> !bus_oe && !$past(bus_oe) && !req_ready)
		else $error("grant before bus floated");
	a_slave_input: assert property (arb_pin_direction_bit |-> !bus_yield_grant_oe)
		else $error("grant pin driven in slave mode");
	a_cs_fast: assert property (select_timing_config && $rose(ale) |-> chip_select_n != 5'h1f)
		else $error("select late with fast timing");
	a_cs_late: assert property (!select_timing_config && $rose(ale) |-> chip_select_n == 5'h1f ##1 chip_select_n != 5'h1f)
		else $error("select timing wrong by default");
endmodule
bind ebu_external_bus_unit ebu_sva u_ebu_sva (.clock, .resetn, .req_valid, .req_ready, .rsp_valid, .rsp_error,
	.single_chip_mode, .address_space_sel, .select_timing_config, .arb_pin_direction_bit, .address_port,
	.segment_address, .bus_oe, .ale, .rd_n, .chip_select_n, .bus_yield_grant_o, .bus_yield_grant_oe);
`default_nettype wire

// ===== bench/ebu_mem_model.sv
// Memory and READY source on the far side of the external bus.
`timescale 1ns/1ps
`default_nettype none
module ebu_mem_model
	import ebu_pkg::*;
(
	input  wire logic        clock,
	input  wire logic [15:0] address_port,
	input  wire ebu_word_t   data_out,
	output var  ebu_word_t   data_in,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic        ready_pol,
	output var  logic        ready_in
);
	ebu_word_t  mem [256];
	ebu_word_t  last = 16'h0;
	logic [3:0] cnt  = 4'h0;
	always_ff @(posedge clock) begin
		if (!wr_n) begin
			mem[address_port[8:1]] <= data_out;
		end
		if (!rd_n) begin
			last <= mem[address_port[8:1]];
		end
		cnt <= (rd_n & wr_n) ? 4'h0 : (cnt == 4'h8) ? cnt : cnt + 4'h1;
	end
	// A released data bus shows the inverse of the last word.
	assign data_in  = !rd_n ? mem[address_port[8:1]] : ~last;
	assign ready_in = (!(rd_n & wr_n) && cnt == 4'h8) ? ready_pol : !ready_pol;
endmodule
`default_nettype wire

// ===== bench/test_ebu_external_bus_unit.sv
// Testbench of the external bus unit.
`timescale 1ns/1ps
`default_nettype none
module test_ebu_external_bus_unit
	import ebu_pkg::*;
;
	logic        clock = 1'b0;
	logic        resetn = 1'b0;
	logic        req_valid = 1'b0;
	logic        req_write = 1'b0;
	logic [23:0] req_addr = 24'h0;
	ebu_word_t   req_wdata = 16'h0;
	logic        single_chip_mode = 1'b0;
	logic [1:0]  address_space_sel = 2'h0;
	ebu_word_t   rsel [4];
	ebu_word_t   bcfg [4];
	ebu_word_t   dcfg;
	logic        select_timing_config = 1'b0;
	logic        arbitration_enable = 1'b1;
	logic        arb_pin_direction_bit = 1'b0;
	logic        hold_request_in = 1'b0;
	logic        bus_yield_grant_i = 1'b0;
	logic        ready_pol = 1'b0;
	logic        req_ready, rsp_valid, rsp_error, bus_oe, ale, rd_n, wr_n, ready_in;
	logic        bus_request_out, bus_yield_grant_o, bus_yield_grant_oe, err_seen, bus_request_out_seen;
	logic [15:0] oe_seen;
	ebu_word_t   rsp_rdata, muxed_data_port_o, muxed_data_port_i, q, mux_a;
	logic [15:0] address_port, muxed_data_port_oe;
	logic [7:0]  segment_address, seg_seen;
	logic [4:0]  chip_select_n, cs_seen;
	int          bad_count = 0;
	int          cmp_count = 0;
	int          low_n;
	always #2 clock = ~clock;
	ebu_external_bus_unit u_ebu_external_bus_unit (.clock, .resetn, .req_valid, .req_ready, .req_write, .req_addr,
		.req_wdata, .rsp_valid, .rsp_rdata, .rsp_error, .single_chip_mode, .address_space_sel,
		.window_range_select(rsel), .window_bus_config(bcfg), .default_bus_config(dcfg), .select_timing_config,
		.arbitration_enable, .arb_pin_direction_bit, .address_port, .segment_address, .bus_oe, .muxed_data_port_o,
		.muxed_data_port_oe, .muxed_data_port_i, .ale, .rd_n, .wr_n, .chip_select_n, .ready_in, .hold_request_in,
		.bus_request_out, .bus_yield_grant_o, .bus_yield_grant_oe, .bus_yield_grant_i);
	ebu_mem_model u_ebu_mem_model (.clock, .address_port, .data_out(muxed_data_port_o),
		.data_in(muxed_data_port_i), .rd_n, .wr_n, .ready_pol, .ready_in);
	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic guard(inout int n);
		@(posedge clock);
		n++;
		if (n > 300) begin
			bad_count++;
			conclude();
		end
	endtask
	function automatic ebu_word_t cfg(logic w8, logic mx, logic [3:0] wt, logic re, logic rp);
		cfg = {4'h0, 1'b1, rp, re, 3'h0, wt, mx, w8};
	endfunction
	// One CPU request, recording what the bus showed while it ran.
	task automatic xfer(input logic w, input logic [23:0] a, input ebu_word_t d);
		int n;
		n = 0;
		low_n = 0;
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		do guard(n); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		do begin
			guard(n);
			if (ale === 1'b1) mux_a = muxed_data_port_o;
			if ((rd_n & wr_n) !== 1'b1) begin
				cs_seen = chip_select_n;
				seg_seen = segment_address;
				bus_request_out_seen = bus_request_out;
				oe_seen = muxed_data_port_oe;
				low_n++;
			end
		end while (rsp_valid !== 1'b1);
		q = rsp_rdata;
		err_seen = rsp_error;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_windows();
		logic [23:0] ad [5] = '{24'h010002, 24'h011004, 24'h021008, 24'h020006, 24'h30000a};
		logic [4:0]  cs [5] = '{5'h1b, 5'h1d, 5'h17, 5'h0f, 5'h1e};
		ebu_word_t   d;
		for (int p = 0; p < 2; p++) begin
			bcfg[3] <= cfg(1'b0, 1'b0, 4'h0, 1'b1, p[0]);
			ready_pol <= p[0];
			select_timing_config <= p[0];
			@(posedge clock);
			for (int i = 0; i < 5; i++) begin
				d = 16'ha5c3 + 16'(i * 257 + p);
				xfer(1'b1, ad[i], d);
				chk(cs_seen, cs[i]);
				chk(oe_seen, (i == 2) ? 16'h00ff : 16'hffff);
				if (i == 1 || i == 2) chk(mux_a, ad[i][15:0]);
				xfer(1'b0, ad[i], d);
				chk(q, (i == 2) ? {8'h00, d[7:0]} : d);
				chk(seg_seen, ad[i][23:16]);
				if (i == 3) chk(24'(low_n > 8), 24'h1);
			end
		end
		$display("windows test done");
	endtask
	task automatic t_space();
		logic [7:0] m [4] = '{8'hff, 8'h0f, 8'h03, 8'h00};
		for (int s = 0; s < 4; s++) begin
			address_space_sel <= 2'(s);
			xfer(1'b1, 24'hab000c, 16'h0);
			chk(seg_seen, 8'hab & m[s]);
		end
		address_space_sel <= 2'h0;
		$display("space test done");
	endtask
	task automatic t_single();
		single_chip_mode <= 1'b1;
		xfer(1'b1, 24'h30000a, 16'hffff);
		chk({err_seen, 23'(low_n)}, 24'h800000);
		single_chip_mode <= 1'b0;
		xfer(1'b0, 24'h30000a, 16'h0);
		chk(q, 16'ha5c3 + 16'h0405);
		$display("single-chip test done");
	endtask
	task automatic t_hold();
		int n;
		n = 0;
		hold_request_in <= 1'b1;
		do guard(n); while (bus_yield_grant_o !== 1'b1);
		chk({bus_oe, req_ready, bus_yield_grant_oe}, 3'h1);
		hold_request_in <= 1'b0;
		do guard(n); while (bus_yield_grant_o !== 1'b0);
		xfer(1'b1, 24'h30000a, 16'h1234);
		chk(cs_seen, 5'h1e);
		chk(bus_request_out_seen, 1'b0);
		$display("hold test done");
	endtask
	task automatic t_slave();
		resetn <= 1'b0;
		arb_pin_direction_bit <= 1'b1;
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		repeat (8) @(posedge clock);
		chk(bus_yield_grant_oe, 1'b0);
		bus_yield_grant_i <= 1'b1;
		xfer(1'b1, 24'h30000a, 16'h0f0f);
		chk(cs_seen, 5'h1e);
		chk(bus_request_out_seen, 1'b1);
		$display("slave test done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rsel = '{16'h0101, 16'h0100, 16'h0201, 16'h0200};
		bcfg = '{cfg(0, 1, 6, 0, 0), cfg(0, 0, 6, 0, 0), cfg(1, 1, 6, 0, 0), cfg(0, 0, 0, 1, 0)};
		dcfg = cfg(0, 0, 6, 0, 0) | 16'h01c0;
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		t_windows();
		t_space();
		t_single();
		t_hold();
		t_slave();
		conclude();
	end
endmodule
`default_nettype wire
